// ---- lcg_channel.sv ----
`timescale 1ns/10ps
`include "lcg_regs.svh"
module lcg_channel #(
    parameter int STEP_CYC = `LCG_MAXOFF_STEP_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic allow,
    input wire logic gate_in,
    input wire logic peak_trip,
    input wire logic [7:0] max_off_setting,
    output logic gate_drive
);
    if (STEP_CYC < 1 || STEP_CYC > 255) begin : g_bad_step
        $error("bad STEP_CYC");
    end
    typedef struct packed {
        lcg_pkg::lcg_sw_e st;
        logic gate_prev;
        logic [7:0] step;
        logic [7:0] code;
        logic drive;
    } lcg_ch_s;
    lcg_ch_s s_q, s_d;
    always_comb begin
        s_d = s_q;
        // The start edge is taken on the combined condition, so a gate input tied high still starts switching.
        s_d.gate_prev = allow && gate_in;
        if (!allow || !gate_in) begin
            s_d.st = lcg_pkg::LCG_IDLE;
            s_d.drive = 1'b0;
        end else begin
            case (s_q.st)
                lcg_pkg::LCG_IDLE: begin
                    if (!s_q.gate_prev) begin
                        s_d.st = lcg_pkg::LCG_ON;
                        s_d.drive = 1'b1;
                    end
                end
                lcg_pkg::LCG_ON: begin
                    if (peak_trip) begin
                        s_d.st = lcg_pkg::LCG_OFF;
                        s_d.drive = 1'b0;
                        s_d.step = 8'h00;
                        s_d.code = 8'h00;
                    end
                end
                lcg_pkg::LCG_OFF: begin
                    if (s_q.code >= max_off_setting) begin
                        s_d.st = lcg_pkg::LCG_ON;
                        s_d.drive = 1'b1;
                    end else if (s_q.step == 8'(STEP_CYC - 1)) begin
                        s_d.step = 8'h00;
                        s_d.code = s_q.code + 8'h01;
                    end else begin
                        s_d.step = s_q.step + 8'h01;
                    end
                end
                default: begin
                    s_d.st = lcg_pkg::LCG_IDLE;
                    s_d.drive = 1'b0;
                end
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '{st: lcg_pkg::LCG_IDLE, gate_prev: 1'b0, step: 8'h00, code: 8'h00, drive: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end
    assign gate_drive = s_q.drive;
endmodule // lcg_channel

// ---- lcg_enable_gating.sv ----
`timescale 1ns/10ps
`include "lcg_regs.svh"
module lcg_enable_gating #(
    parameter int CHANNELS = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [CHANNELS-1:0] supply_uvlo,
    input wire logic [CHANNELS-1:0] boot_below_uvlo,
    input wire logic [CHANNELS-1:0] boot_above_hyst,
    input wire logic [CHANNELS-1:0] current_sense_positive_uvlo,
    input wire logic thermal_shutdown,
    input wire logic enable_undervoltage_input,
    input wire logic spi_bypass_enable_level,
    input wire logic [CHANNELS-1:0] channel_output_enable_bit,
    input wire logic [CHANNELS-1:0] dimming_gate_input,
    input wire logic [CHANNELS-1:0] peak_trip,
    input wire logic [CHANNELS-1:0] setting_write,
    input wire logic [7:0] setting_wdata,
    input wire logic [1:0] setting_sel,
    input wire logic setting_commit,
    output logic [CHANNELS-1:0] channel_enable,
    output logic [CHANNELS-1:0] gate_drive,
    output logic [CHANNELS*8-1:0] peak_threshold_setting,
    output logic [CHANNELS*8-1:0] off_time_setting,
    output logic [CHANNELS*8-1:0] max_off_time_setting
);
    if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
        $error("bad CHANNELS");
    end
    if (`LCG_APPLY_CYC < 1) begin : g_bad_apply
        $error("apply delay below one cycle");
    end
    typedef struct packed {
        logic [CHANNELS-1:0] boot_lock;
        logic [CHANNELS-1:0] en;
        logic [CHANNELS*8-1:0] pk;
        logic [CHANNELS*8-1:0] toff;
        logic [CHANNELS*8-1:0] moff;
        logic [CHANNELS*8-1:0] pk_sh;
        logic [CHANNELS*8-1:0] toff_sh;
        logic [CHANNELS*8-1:0] moff_sh;
    } lcg_top_s;
    lcg_top_s s_q, s_d;
    logic [CHANNELS-1:0] gate_w;
    logic [CHANNELS-1:0] allow_w;
    always_comb begin
        s_d = s_q;
        allow_w = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            if (boot_below_uvlo[i]) begin
                s_d.boot_lock[i] = 1'b1;
            end else if (boot_above_hyst[i]) begin
                s_d.boot_lock[i] = 1'b0;
            end
            // Each channel's lockouts gate only that channel; thresholds are fixed outside.
            // The channel sees the same-cycle conditions, so its drive never outlives the enable.
            allow_w[i] = !supply_uvlo[i] && !s_d.boot_lock[i] && !current_sense_positive_uvlo[i]
                && !thermal_shutdown
                && enable_undervoltage_input
                && (channel_output_enable_bit[i] || spi_bypass_enable_level);
            s_d.en[i] = allow_w[i] && dimming_gate_input[i];
            if (setting_write[i]) begin
                if (setting_sel == 2'h0) begin
                    s_d.pk_sh[i*8 +: 8] = setting_wdata;
                end else if (setting_sel == 2'h1) begin
                    s_d.toff_sh[i*8 +: 8] = setting_wdata;
                end else if (setting_sel == 2'h2) begin
                    s_d.moff_sh[i*8 +: 8] = setting_wdata;
                end
            end
        end
        if (setting_commit) begin
            s_d.pk = s_q.pk_sh;
            s_d.toff = s_q.toff_sh;
            s_d.moff = s_q.moff_sh;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q.boot_lock <= '1;
            s_q.en <= '0;
            s_q.pk <= {CHANNELS{`LCG_SETTING_RESET}};
            s_q.toff <= {CHANNELS{`LCG_SETTING_RESET}};
            s_q.moff <= {CHANNELS{`LCG_SETTING_RESET}};
            s_q.pk_sh <= {CHANNELS{`LCG_SETTING_RESET}};
            s_q.toff_sh <= {CHANNELS{`LCG_SETTING_RESET}};
            s_q.moff_sh <= {CHANNELS{`LCG_SETTING_RESET}};
        end else begin
            s_q <= s_d;
        end
    end
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        lcg_channel u_ch (
            .clk(clk),
            .rstn(rstn),
            .allow(allow_w[g]),
            .gate_in(dimming_gate_input[g]),
            .peak_trip(peak_trip[g]),
            .max_off_setting(s_q.moff[g*8 +: 8]),
            .gate_drive(gate_w[g])
        );
    end
    assign channel_enable = s_q.en;
    assign gate_drive = gate_w;
    assign peak_threshold_setting = s_q.pk;
    assign off_time_setting = s_q.toff;
    assign max_off_time_setting = s_q.moff;
endmodule // lcg_enable_gating

// ---- lcg_enable_gating_monitor.sv ----
`timescale 1ns/10ps
module lcg_enable_gating_monitor #(
    parameter int CHANNELS = 2
) (
    input logic clk,
    input logic rstn,
    input logic [CHANNELS-1:0] supply_uvlo,
    input logic [CHANNELS-1:0] boot_below_uvlo,
    input logic [CHANNELS-1:0] boot_above_hyst,
    input logic [CHANNELS-1:0] current_sense_positive_uvlo,
    input logic thermal_shutdown,
    input logic enable_undervoltage_input,
    input logic [CHANNELS-1:0] dimming_gate_input,
    input logic [CHANNELS-1:0] peak_trip,
    input logic setting_commit,
    input logic [CHANNELS-1:0] channel_enable,
    input logic [CHANNELS-1:0] gate_drive,
    input logic [CHANNELS*8-1:0] peak_threshold_setting,
    input logic [CHANNELS*8-1:0] off_time_setting,
    input logic [CHANNELS*8-1:0] max_off_time_setting
);
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_rail_lock: assert property (1 |=> (channel_enable & $past(supply_uvlo | current_sense_positive_uvlo)) == '0)
        else $error("enable during rail lockout");
    a_boot_hold: assert property ((boot_below_uvlo[0] && !boot_above_hyst[0]) ##1 !boot_above_hyst[0] |=> !channel_enable[0])
        else $error("enable during boot lockout");
    a_thermal_stop: assert property (thermal_shutdown |=> channel_enable == '0)
        else $error("enable during thermal shutdown");
    a_enable_low: assert property (!enable_undervoltage_input |=> channel_enable == '0)
        else $error("enable while enable input low");
    a_dim_low: assert property (1 |=> (gate_drive & ~$past(dimming_gate_input)) == '0)
        else $error("drive while gate input low");
    a_gate_start: assert property ($rose(dimming_gate_input[0]) ##1 channel_enable[0] |-> gate_drive[0])
        else $error("gate edge did not start drive");
    a_drive_enable: assert property ((gate_drive & ~channel_enable) == '0)
        else $error("drive without channel enable");
    a_reset_value: assert property ($rose(rstn) |-> {peak_threshold_setting, off_time_setting} == {2*CHANNELS{8'h7F}})
        else $error("setting reset value wrong");
    a_hold_settings: assert property (!setting_commit |=> $stable({peak_threshold_setting, max_off_time_setting}))
        else $error("setting changed without commit");
endmodule // lcg_enable_gating_monitor
bind lcg_enable_gating lcg_enable_gating_monitor #(.CHANNELS(CHANNELS)) mon_u (.*);

// ---- lcg_enable_gating_tb.sv ----
`timescale 1ns/10ps
`include "lcg_regs.svh"
module lcg_enable_gating_tb;
    typedef struct {time t; logic [51:0] m; logic [51:0] v;} lcg_note_s;
    localparam logic [51:0] MS = {4'h0, {48{1'b1}}};
    localparam logic [51:0] MC = {2'b11, 50'h0};
    localparam logic [51:0] MG = {4'h3, 48'h0};
    logic clk = 1'b0, rstn = 1'b0, th = 1'b0, en = 1'b1, by = 1'b0, cm;
    logic [1:0] su = '0, bb = '0, bh = 2'b11, cs = '0, oe = 2'b11, dim = '0, pk = '0, sw, sl, ce, gd, ec;
    logic [7:0] wd;
    logic [15:0] ps, os, ms;
    logic [15:0] es [3] = '{default: 16'h7F7F};
    logic [31:0] seed = 32'h71f5;
    lcg_note_s nq [$];
    int error_cnt = 0, checked = 0;
    always #10 clk = ~clk;
    lcg_host_model host_u (.clk(clk), .setting_write(sw), .setting_wdata(wd), .setting_sel(sl), .setting_commit(cm));
    lcg_enable_gating dut_u (.clk(clk), .rstn(rstn), .supply_uvlo(su), .boot_below_uvlo(bb), .boot_above_hyst(bh),
        .current_sense_positive_uvlo(cs), .thermal_shutdown(th), .enable_undervoltage_input(en),
        .spi_bypass_enable_level(by), .channel_output_enable_bit(oe), .dimming_gate_input(dim), .peak_trip(pk),
        .setting_write(sw), .setting_wdata(wd), .setting_sel(sl), .setting_commit(cm), .channel_enable(ce),
        .gate_drive(gd), .peak_threshold_setting(ps), .off_time_setting(os), .max_off_time_setting(ms));
    task automatic note(input logic [51:0] m, input logic [51:0] v);
        repeat (3) @(posedge clk);
        nq.push_back('{$time + 10, m, v});
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input logic [51:0] seen, input logic [51:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim;
        if (error_cnt == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(negedge clk) if (nq.size() > 0 && nq[0].t <= $time) begin
        check({ce, gd, ps, os, ms} & nq[0].m, nq[0].v);
        nq.pop_front();
    end
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        note(MS, {4'h0, es[0], es[1], es[2]});
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            host_u.send(seed[0], 2'(i % 4), seed[15:8] | 8'h01);
            if (i % 4 != 3) es[i % 4][8 * seed[0] +: 8] = seed[15:8] | 8'h01;
            note(MS, {4'h0, es[0], es[1], es[2]});
        end
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            {pk, dim, oe, by, en, th, cs, su} <= {seed[19:14], seed[13], |seed[12:11], &seed[10:8],
                seed[5:4] & seed[7:6], seed[1:0] & seed[3:2]};
            ec = ~(seed[1:0] & seed[3:2]) & ~(seed[5:4] & seed[7:6]) & ({2{seed[13]}} | seed[15:14]) & seed[17:16];
            note(MC, {ec & {2{~&seed[10:8] & |seed[12:11]}}, 50'h0});
        end
        {pk, dim, oe, by, en, th} <= {2'b00, 2'b11, 2'b11, 1'b0, 1'b1, 1'b0};
        {cs, su, bb, bh} <= {2'b00, 2'b00, 2'b01, 2'b10};
        note(MC, {2'b10, 50'h0});
        bb <= '0;
        note(MC, {2'b10, 50'h0});
        bh <= 2'b11;
        note(MC, {2'b11, 50'h0});
        dim <= '0;
        note(MC | MG, '0);
        dim <= 2'b11;
        note(MG, {4'h3, 48'h0});
        pk <= 2'b01;
        @(posedge clk);
        pk <= '0;
        repeat (`LCG_MAXOFF_STEP_CYC * es[2][7:0]) @(posedge clk);
        nq.push_back('{$time + 10, MG, {4'h2, 48'h0}});
        @(posedge clk);
        nq.push_back('{$time + 10, MG, {4'h3, 48'h0}});
        th <= 1'b1;
        note(MC | MG, '0);
        th <= 1'b0;
        dim <= '0;
        note(MG, '0);
        by <= 1'b1;
        oe <= '0;
        dim <= 2'b11;
        note(MC, {2'b11, 50'h0});
        en <= 1'b0;
        note(MC, '0);
        repeat (2) @(posedge clk);
        end_sim();
    end
endmodule // lcg_enable_gating_tb

// ---- lcg_host_model.sv ----
`timescale 1ns/10ps
module lcg_host_model (
    input logic clk,
    output logic [1:0] setting_write = '0,
    output logic [7:0] setting_wdata = '0,
    output logic [1:0] setting_sel = '0,
    output logic setting_commit = 1'b0
);
    task send(input logic ch, input logic [1:0] sel, input logic [7:0] d);
        if (sel != 2'd0 && d == 8'h00) return;
        setting_write[ch] <= 1'b1;
        setting_sel <= sel;
        setting_wdata <= d;
        @(posedge clk);
        setting_write <= '0;
        setting_commit <= 1'b1;
        setting_wdata <= ~d;
        @(posedge clk);
        setting_commit <= 1'b0;
    endtask
endmodule // lcg_host_model

// ---- lcg_pkg.sv ----
package lcg_pkg;
    typedef enum logic [1:0] {
        LCG_IDLE = 2'b00,
        LCG_ON = 2'b01,
        LCG_OFF = 2'b10
    } lcg_sw_e;
endpackage

// ---- lcg_regs.svh ----
`ifndef LCG_REGS_SVH
`define LCG_REGS_SVH
`define LCG_CLK_PERIOD_NS 20
`define LCG_APPLY_NS 100
`define LCG_APPLY_CYC (`LCG_APPLY_NS / `LCG_CLK_PERIOD_NS)
`define LCG_SETTING_RESET 8'h7F
`define LCG_MAXOFF_STEP_NS 251
`define LCG_MAXOFF_STEP_CYC ((`LCG_MAXOFF_STEP_NS + `LCG_CLK_PERIOD_NS - 1) / `LCG_CLK_PERIOD_NS)
`endif
